// file: rtl/fpm_front_end.sv
// Pin-function multiplexer and serial lane engine of a serial flash slave
`timescale 1ns/1ps

// Behaviour
// - Quad enable set: data line 2 pin loses write protect, is data only.
// - Quad enable set: shared pin loses pause and reset, is data line 3.
// - No dedicated reset, quad off: select bit zero pause, one reset.
// - Dedicated reset enabled, quad off: shared pin is pause regardless.
// - Dedicated reset function is enabled after power-up.
// - Dedicated reset disabled, quad off: select bit chooses pause or reset.
// - Function configuration bit 0 set disables the dedicated reset.
// - Pause low while selected freezes transfer; resumes same sequence after.
// - Pause and select both low put serial output in high impedance.
// - Hardware reset low enters reset with outputs high impedance.
// - Only modes 0 and 3; host idles clock low or high.
// - Sample on rising clock edge, change outputs from falling edge.
// - Dual transfers use serial in and out as data lines 0 and 1.
// - Quad transfers use all four pins as data lines 0 to 3.
// - Select high: deselected, outputs high impedance, input ignored.
module fpm_front_end #(
  parameter bit HAS_DED_RST = 1'b1  // Package has a dedicated reset pin
) (
  input  wire logic                core_clk,          // System clock
  input  wire logic                rst_n,             // Async reset, active low
  input  wire logic                clkEn,             // Freezes all state when low
  input  wire logic                sckPin,            // Serial clock from host
  input  wire logic                csPinN,            // Chip select, active low
  input  wire logic                dedRstPinN,        // Dedicated reset pin
  input  wire logic [3:0]          dataIn,            // Data line 0..3 pin levels
  input  wire logic                quadIoEnableBit,   // Quad enable config bit
  input  wire logic                pinRoleSelectBit,  // Pause or reset select bit
  input  wire logic                funcRegWrite,      // Write strobe, function bit 0
  input  wire logic                funcRegBit0,       // Dedicated reset disable value
  input  wire logic                quadCommandMode,   // All phases on four lanes if quad enabled
  input  wire logic [1:0]          laneSel,           // Lane width for this phase
  input  wire logic                dirOut,            // Core drives data this phase
  input  wire logic [7:0]          txByte,            // Next byte to send
  output logic      [3:0]          dataOut,           // Data line output levels
  output logic      [3:0]          dataOe,            // Data line output enables
  output logic      [7:0]          rxByte,            // Last byte received
  output logic                     rxValid,           // Pulse: rxByte updated
  output logic                     txTaken,           // Pulse: txByte consumed
  output logic                     selected,          // Device is selected
  output logic                     pauseActive,       // Transfer frozen by pause
  output logic                     hwResetActive,     // Hardware reset in force
  output logic                     writeProtectN,     // Write protect level, low
  output logic                     dedRstDisabled,    // Function bit 0 state
  output fpm_pkg::fpm_role_t       pinRole            // Current pin roles
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  fpm_pkg::fpm_pins_t pinsRaw;
  fpm_pkg::fpm_pins_t syncA_q;
  fpm_pkg::fpm_pins_t syncB_q;
  logic               sckDly_q;

  assign pinsRaw = '{sck: sckPin, csN: csPinN, dedRstN: dedRstPinN, data: dataIn};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= fpm_pkg::PINS_RST;
      syncB_q <= fpm_pkg::PINS_RST;
    end else if (clkEn) begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
    end
  end

  // Resets low like mode 0 idle; a mode 3 idle high is first seen while deselected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckDly_q <= 1'b0;
    end else if (clkEn) begin
      sckDly_q <= syncB_q.sck;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Function configuration bit 0

  logic rstDisable_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstDisable_q <= fpm_pkg::RST_DIS_RST;
    end else if (clkEn && funcRegWrite) begin
      rstDisable_q <= funcRegBit0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin role decision

  fpm_pkg::fpm_role_t roleD;
  fpm_pkg::fpm_role_t role_q;
  logic               dedRstOn;

  assign dedRstOn = HAS_DED_RST && !rstDisable_q;

  // Purely combinational from the config bits, so any change is seen next cycle
  always_comb begin
    roleD        = '0;
    roleD.wpRole = !quadIoEnableBit;
    if (!quadIoEnableBit) begin
      if (dedRstOn) begin
        roleD.pauseRole = 1'b1;
      end else if (pinRoleSelectBit) begin
        roleD.resetRole = 1'b1;
      end else begin
        roleD.pauseRole = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      role_q <= fpm_pkg::ROLE_RST;
    end else if (clkEn) begin
      role_q <= roleD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Select, pause, reset and clock edges

  logic isSel;
  logic pauseNow;
  logic resetNow;
  logic sckRise;
  logic sckFall;
  logic runEdge;

  assign isSel    = !syncB_q.csN;
  assign pauseNow = role_q.pauseRole && !syncB_q.data[3] && isSel;
  assign resetNow = (role_q.resetRole && !syncB_q.data[3])
                 || (dedRstOn && !syncB_q.dedRstN);
  // Edge detection works for either idle level, so modes 0 and 3 both run
  assign sckRise  = syncB_q.sck && !sckDly_q;
  assign sckFall  = !syncB_q.sck && sckDly_q;
  // Edges seen while paused are dropped, counters keep their place
  assign runEdge  = isSel && !pauseNow && !resetNow;

  //////////////////////////////////////////////////////////////////////////////
  // Lane width

  fpm_pkg::fpm_lane_t lane;
  logic [2:0]         step;
  logic [3:0]         laneMask;

  always_comb begin
    lane = fpm_pkg::LANE_SINGLE;
    if (quadCommandMode || (laneSel == fpm_pkg::LANE_QUAD)) begin
      lane = quadIoEnableBit ? fpm_pkg::LANE_QUAD : fpm_pkg::LANE_SINGLE;
    end else if (laneSel == fpm_pkg::LANE_DUAL) begin
      lane = fpm_pkg::LANE_DUAL;
    end
  end

  always_comb begin
    unique case (lane)
      fpm_pkg::LANE_SINGLE: begin
        step     = fpm_pkg::STEP_SINGLE;
        laneMask = fpm_pkg::MASK_SINGLE;
      end
      fpm_pkg::LANE_DUAL: begin
        step     = fpm_pkg::STEP_DUAL;
        laneMask = fpm_pkg::MASK_DUAL;
      end
      default: begin
        step     = fpm_pkg::STEP_QUAD;
        laneMask = fpm_pkg::MASK_QUAD;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive path, rising edge

  logic [2:0] rxCnt_q;
  logic [7:0] rxShift_q;
  logic [7:0] rxBits;
  logic [7:0] rxNext;
  logic [2:0] rxCntNext;

  always_comb begin
    unique case (lane)
      fpm_pkg::LANE_SINGLE: rxBits = {7'h00, syncB_q.data[0]};
      fpm_pkg::LANE_DUAL:   rxBits = {6'h00, syncB_q.data[1:0]};
      default:              rxBits = {4'h0, syncB_q.data};
    endcase
  end

  assign rxNext    = (rxShift_q << step) | rxBits;
  assign rxCntNext = rxCnt_q + step;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt_q   <= fpm_pkg::CNT_RST;
      rxShift_q <= fpm_pkg::BYTE_RST;
      rxByte    <= fpm_pkg::BYTE_RST;
      rxValid   <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (!isSel || resetNow) begin
        rxCnt_q   <= fpm_pkg::CNT_RST;
        rxShift_q <= fpm_pkg::BYTE_RST;
      end else if (runEdge && sckRise && !dirOut) begin
        rxShift_q <= rxNext;
        rxCnt_q   <= rxCntNext;
        if (rxCntNext == fpm_pkg::CNT_RST) begin
          rxByte  <= rxNext;
          rxValid <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path, falling edge

  logic [2:0] txCnt_q;
  logic [7:0] txShift_q;
  logic [7:0] txSrc;

  // A new byte is taken at the first falling edge of each byte slot
  assign txSrc = (txCnt_q == fpm_pkg::CNT_RST) ? txByte : txShift_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txCnt_q   <= fpm_pkg::CNT_RST;
      txShift_q <= fpm_pkg::BYTE_RST;
      dataOut   <= 4'h0;
      txTaken   <= 1'b0;
    end else if (clkEn) begin
      txTaken <= 1'b0;
      if (!isSel || resetNow) begin
        txCnt_q <= fpm_pkg::CNT_RST;
      end else if (runEdge && sckFall && dirOut) begin
        txShift_q <= txSrc << step;
        txCnt_q   <= txCnt_q + step;
        txTaken   <= (txCnt_q == fpm_pkg::CNT_RST);
        unique case (lane)
          fpm_pkg::LANE_SINGLE: dataOut <= {2'h0, txSrc[7], 1'b0};
          fpm_pkg::LANE_DUAL:   dataOut <= {2'h0, txSrc[7:6]};
          default:              dataOut <= txSrc[7:4];
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output enables and status

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOe <= 4'h0;
    end else if (clkEn) begin
      if (!isSel || pauseNow || resetNow || !dirOut) begin
        dataOe <= 4'h0;
      end else begin
        dataOe <= laneMask;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selected      <= 1'b0;
      pauseActive   <= 1'b0;
      hwResetActive <= 1'b0;
    end else if (clkEn) begin
      selected      <= isSel;
      pauseActive   <= pauseNow;
      // Reset must not land during an internal write; the host keeps that
      hwResetActive <= resetNow;
    end
  end

  // Outside the protect role the level reads as not protected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      writeProtectN <= 1'b1;
    end else if (clkEn) begin
      writeProtectN <= role_q.wpRole ? syncB_q.data[2] : 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dedRstDisabled <= fpm_pkg::RST_DIS_RST;
      pinRole        <= fpm_pkg::ROLE_RST;
    end else if (clkEn) begin
      dedRstDisabled <= rstDisable_q;
      pinRole        <= role_q;
    end
  end

endmodule : fpm_front_end

// file: rtl/fpm_pkg.sv
// Shared types and constants for the flash pin-function and serial front end
package fpm_pkg;

  // Width of the serial lanes used for one transfer phase
  typedef enum logic [1:0] {
    LANE_SINGLE,
    LANE_DUAL,
    LANE_QUAD
  } fpm_lane_t;

  // Role currently given to the two multiplexed pins
  typedef struct packed {
    logic wpRole;     // Data line 2 pin acts as write protect
    logic pauseRole;  // Data line 3 pin acts as pause
    logic resetRole;  // Data line 3 pin acts as hardware reset
  } fpm_role_t;

  // Synchronised pin group: sck, select, dedicated reset, four data lines
  typedef struct packed {
    logic       sck;
    logic       csN;
    logic       dedRstN;
    logic [3:0] data;
  } fpm_pins_t;

  localparam int         BYTE_BITS     = 8;
  localparam logic [2:0] STEP_SINGLE   = 3'h1;
  localparam logic [2:0] STEP_DUAL     = 3'h2;
  localparam logic [2:0] STEP_QUAD     = 3'h4;
  localparam logic [3:0] MASK_SINGLE   = 4'h2;
  localparam logic [3:0] MASK_DUAL     = 4'h3;
  localparam logic [3:0] MASK_QUAD     = 4'hF;
  localparam logic [2:0] CNT_RST       = 3'h0;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic       RST_DIS_RST   = 1'b0;
  localparam fpm_pins_t  PINS_RST      = '{sck: 1'b0, csN: 1'b1, dedRstN: 1'b1, data: 4'hF};
  localparam fpm_role_t  ROLE_RST      = '{wpRole: 1'b1, pauseRole: 1'b1, resetRole: 1'b0};

endpackage : fpm_pkg

// file: verif/fpm_front_end_asserts.sv
// Checker of pin roles, output enables and receive pulses
`timescale 1ns/1ps
module fpm_front_end_asserts #(
  parameter bit HAS_DED_RST = 1'b1  // Dedicated reset pin fitted
) (
  input wire logic               core_clk,          // Clock
  input wire logic               rst_n,             // Reset
  input wire logic               clkEn,             // Run
  input wire logic               csPinN,            // Select
  input wire logic               quadIoEnableBit,   // Quad
  input wire logic               pinRoleSelectBit,  // Role bit
  input wire logic               funcRegWrite,      // Write
  input wire logic               funcRegBit0,       // Value
  input wire logic [3:0]         dataOe,            // Enables
  input wire logic               rxValid,           // Byte in
  input wire logic               pauseActive,       // Pause
  input wire logic               hwResetActive,     // Reset
  input wire logic               writeProtectN,     // Protect
  input wire logic               dedRstDisabled,    // Disable
  input wire fpm_pkg::fpm_role_t pinRole            // Roles
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic qOn   = quadIoEnableBit && clkEn;
  wire logic qOff  = !quadIoEnableBit && clkEn;
  wire logic useFn = !HAS_DED_RST || dedRstDisabled;
  //////////////////////////////////////////////////////////////////////////////
  a_quad_roles: assert property (qOn[*4] |-> pinRole == 3'h0 && writeProtectN)
    else $error("pin roles kept in quad");
  a_pause_role: assert property (
    (qOff && (!pinRoleSelectBit || !useFn))[*4] |-> pinRole == 3'h6)
    else $error("shared pin not pause");
  a_reset_role: assert property ((qOff && pinRoleSelectBit && useFn)[*4] |-> pinRole == 3'h5)
    else $error("shared pin not reset");
  a_disable_bit: assert property (
    funcRegWrite && clkEn ##1 !funcRegWrite[*3] |-> dedRstDisabled == $past(funcRegBit0, 3))
    else $error("disable bit not loaded");
  a_desel_quiet: assert property (csPinN[*6] |-> dataOe == 4'h0)
    else $error("driving while deselected");
  a_pause_hiz: assert property (pauseActive[*3] |-> dataOe == 4'h0 && !rxValid)
    else $error("activity during pause");
  a_reset_hiz: assert property (hwResetActive[*3] |-> dataOe == 4'h0)
    else $error("driving during reset");
  a_lane_mask: assert property (dataOe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lane enables");
  a_rx_pulse: assert property (rxValid |=> !rxValid[*3])
    else $error("receive pulse too long");
  c_pause: cover property (pauseActive ##1 !pauseActive);
  c_quad_rx: cover property (rxValid && quadIoEnableBit);
  c_reset: cover property (hwResetActive && !csPinN);
endmodule : fpm_front_end_asserts

// file: verif/fpm_spi_host.sv
// Host model: frames in modes 0 and 3, byte slots on 1, 2 or 4 lanes
`timescale 1ns/1ps
module fpm_spi_host (
  input  wire logic [3:0] rx,       // Resolved data lines
  input  wire logic       core_clk, // Paces the serial clock
  output logic            sck,      // Serial clock
  output logic            csN,      // Select, active low
  output logic [3:0]      oe,       // Host drives line
  output logic [3:0]      dat       // Host line levels
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    oe  = 4'hF;
    dat = 4'hF;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : hw
  task automatic frame(input logic on, input logic cpol);
    sck = cpol;
    hw(4);
    csN = !on;
    oe  = 4'hF;
    dat = 4'hF;
    hw(4);
  endtask : frame
  task automatic xfer(input logic [7:0] b, input int st, input logic [3:0] o,
                      input int pz, output logic [7:0] g);
    g  = 8'h00;
    oe = o;
    for (int i = 0; i < 8 / st; i++) begin
      sck = 1'b0;
      dat = st == 4 ? b[7:4] : st == 2 ? {dat[3:2], b[7:6]} : {dat[3:1], b[7]};
      b   = b << st;
      if (i == pz) begin
        // Stray clocks while paused must not count
        dat[3] = 1'b0;
        hw(6);
        repeat (2) begin
          sck = 1'b1;
          hw(4);
          sck = 1'b0;
          hw(4);
        end
        dat[3] = 1'b1;
        hw(6);
      end
      hw(4);
      sck = 1'b1;
      hw(4);
      g = st == 4 ? {g[3:0], rx} : st == 2 ? {g[5:0], rx[1:0]} : {g[6:0], rx[1]};
    end
  endtask : xfer
endmodule : fpm_spi_host

// file: verif/tb.sv
// Bench top: role sweep, serial modes and lanes, pause, reset, deselect
`timescale 1ns/1ps
`define CK(n, e, v) begin checked++; if ((v) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb;
  logic               core_clk, rst_n, clkEn, sckPin, csPinN, dedRstPinN, quadCommandMode;
  logic               quadIoEnableBit, pinRoleSelectBit, funcRegWrite, funcRegBit0, dirOut;
  logic               rxValid, txTaken, selected, pauseActive, hwResetActive;
  logic               tgl      = 1'b0;
  logic               sawPause = 1'b0;
  logic               writeProtectN, dedRstDisabled;
  logic [1:0]         laneSel;
  logic [3:0]         dataIn, dataOut, dataOe, hOe, hDat, c;
  logic [7:0]         txByte, rxByte, g;
  fpm_pkg::fpm_role_t pinRole;
  int                 errors, checked, rxCnt, n0, tkCnt, n1;
  logic [3:0]         cfg [4] = '{4'h0, 4'h8, 4'h9, 4'h6};
  // Undriven lines toggle so a stale level cannot pass
  assign dataIn = (dataOe & dataOut) | (~dataOe & hOe & hDat) | (~dataOe & ~hOe & {4{tgl}});
  fpm_front_end #(.HAS_DED_RST(1'b1)) u_fpm_front_end (
    .core_clk, .rst_n, .clkEn, .sckPin, .csPinN, .dedRstPinN, .dataIn, .quadIoEnableBit,
    .pinRoleSelectBit, .funcRegWrite, .funcRegBit0, .quadCommandMode, .laneSel, .dirOut,
    .txByte, .dataOut, .dataOe, .rxByte, .rxValid, .txTaken, .selected, .pauseActive,
    .hwResetActive, .writeProtectN, .dedRstDisabled, .pinRole);
  fpm_spi_host u_fpm_spi_host (.rx(dataIn), .core_clk, .sck(sckPin), .csN(csPinN),
    .oe(hOe), .dat(hDat));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tgl <= ~tgl;
    if (rxValid === 1'b1) rxCnt <= rxCnt + 1;
    if (pauseActive === 1'b1) sawPause <= 1'b1;
    if (txTaken === 1'b1) tkCnt <= tkCnt + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wait_rx;
    for (int i = 0; i < 20 && rxCnt == n0; i++) cyc(1);
    if (rxCnt == n0) begin
      errors++;
      finish_test();
    end
  endtask : wait_rx
  task automatic fn_write(input logic b);
    funcRegBit0  = b;
    funcRegWrite = 1'b1;
    cyc(1);
    funcRegWrite = 1'b0;
    cyc(6);
  endtask : fn_write
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, funcRegWrite, funcRegBit0, quadIoEnableBit, pinRoleSelectBit} = 5'h0;
    {quadCommandMode, dirOut, laneSel, txByte} = 12'h0;
    {clkEn, dedRstPinN} = 2'h3;
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    `CK("pinRole", 3'h6, pinRole)
    `CK("dedRstDisabled", 1'b0, dedRstDisabled)
    u_fpm_spi_host.dat[2] = 1'b0;
    for (int k = 0; k < 8; k++) begin
      {quadIoEnableBit, pinRoleSelectBit} = k[2:1];
      fn_write(k[0]);
      `CK("dedRstDisabled", k[0], dedRstDisabled)
      `CK("pinRole", {!k[2], !k[2] && !(k[1] && k[0]), !k[2] && k[1] && k[0]}, pinRole)
      `CK("writeProtectN", k[2], writeProtectN)
    end
    {quadIoEnableBit, pinRoleSelectBit, u_fpm_spi_host.dat[2]} = 3'h1;
    fn_write(1'b0);
    $display("role sweep done");
    dedRstPinN = 1'b0;
    cyc(6);
    `CK("hwResetActive", 1'b1, hwResetActive)
    fn_write(1'b1);
    `CK("hwResetActive", 1'b0, hwResetActive)
    pinRoleSelectBit = 1'b1;
    u_fpm_spi_host.dat[3] = 1'b0;
    cyc(6);
    `CK("hwResetActive", 1'b1, hwResetActive)
    {dedRstPinN, u_fpm_spi_host.dat[3], pinRoleSelectBit} = 3'h6;
    cyc(6);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      c = cfg[k];
      {quadIoEnableBit, quadCommandMode, laneSel, dirOut} = {c[2], c[2], c[1:0], 1'b0};
      txByte = 8'h3C ^ 8'(k);
      u_fpm_spi_host.frame(1'b1, c[3]);
      `CK("selected", 1'b1, selected)
      n0 = rxCnt;
      u_fpm_spi_host.xfer(8'hA5 ^ 8'(k), 1 << c[1:0], 4'hF, 9, g);
      wait_rx();
      `CK("rxByte", 8'hA5 ^ 8'(k), rxByte)
      dirOut = 1'b1;
      n1     = tkCnt;
      u_fpm_spi_host.xfer(8'h00, 1 << c[1:0], c[1] ? 4'h0 : c[0] ? 4'hC : 4'hD, 9, g);
      `CK("txByte", 8'h3C ^ 8'(k), g)
      `CK("txTaken", n1 + 1, tkCnt)
      u_fpm_spi_host.frame(1'b0, c[3]);
      `CK("selected", 1'b0, selected)
    end
    {quadIoEnableBit, quadCommandMode, laneSel, dirOut} = 5'h0;
    $display("lane test done");
    u_fpm_spi_host.frame(1'b1, 1'b0);
    n0 = rxCnt;
    u_fpm_spi_host.xfer(8'hB4, 1, 4'hF, 3, g);
    wait_rx();
    `CK("rxByte", 8'hB4, rxByte)
    `CK("sawPause", 1'b1, sawPause)
    dirOut = 1'b1;
    cyc(4);
    `CK("dataOe", 4'h2, dataOe)
    u_fpm_spi_host.dat[3] = 1'b0;
    cyc(4);
    `CK("dataOe", 4'h0, dataOe)
    pinRoleSelectBit = 1'b1;
    cyc(4);
    `CK("hwResetActive", 1'b1, hwResetActive)
    `CK("dataOe", 4'h0, dataOe)
    {u_fpm_spi_host.dat[3], pinRoleSelectBit, dirOut} = 3'h4;
    cyc(4);
    u_fpm_spi_host.frame(1'b0, 1'b0);
    $display("pause test done");
    u_fpm_spi_host.xfer(8'h0F, 1, 4'hF, 9, g);
    cyc(8);
    `CK("rxByte", 8'hB4, rxByte)
    dirOut = 1'b1;
    cyc(4);
    `CK("dataOe", 4'h0, dataOe)
    dirOut = 1'b0;
    $display("deselect test done");
    clkEn           = 1'b0;
    quadIoEnableBit = 1'b1;
    cyc(4);
    `CK("pinRole", 3'h6, pinRole)
    clkEn = 1'b1;
    cyc(4);
    `CK("pinRole", 3'h0, pinRole)
    $display("enable test done");
    finish_test();
  end
  initial begin
    #3000000;
    errors++;
    finish_test();
  end
endmodule : tb
bind fpm_front_end fpm_front_end_asserts #(.HAS_DED_RST(HAS_DED_RST)) u_fpm_front_end_asserts (
  .core_clk, .rst_n, .clkEn, .csPinN, .quadIoEnableBit, .pinRoleSelectBit, .funcRegWrite,
  .funcRegBit0, .dataOe, .rxValid, .pauseActive, .hwResetActive, .writeProtectN,
  .dedRstDisabled, .pinRole);
